// *** pager_packet_sequencer.v ***
// Block-by-block packet sequencer and all-frame counter
`timescale 1ns/1ps
`include "pager_packet_defs.vh"
module pager_packet_sequencer #(
    parameter PHASES = 4,
    parameter SLOTS = 8,
    parameter DATA_W = 19,
    parameter CNT_W = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Decoded words of one block, from the decoder core
    input wire word_valid,
    input wire [1:0] word_phase,
    input wire [2:0] word_slot,
    input wire [6:0] word_number,
    input wire [2:0] word_kind,
    input wire [6:0] word_aux,
    input wire [DATA_W-1:0] word_data,
    input wire block_done,
    input wire frame_end,
    // Configuration levels
    input wire biw_report_en,
    input wire forced_allframe_bit,
    input wire temp_address_pending,
    // Serial packet link to the host
    input wire link_sck,
    input wire link_ss_n,
    input wire link_mosi,
    output wire link_miso,
    // Status
    output reg block_busy,
    output reg word_overrun,
    output reg packet_pending,
    output reg frame_done,
    output reg [CNT_W-1:0] allframe_count,
    output reg allframe_mode
);

localparam N = PHASES * SLOTS;
localparam IW = $clog2(N);
localparam EW = 3 + 7 + 7 + DATA_W;

// Sequencer states
localparam S_IDLE = 2'd0;
localparam S_SCAN = 2'd1;

reg [1:0] state;
reg [IW-1:0] scan_idx;
reg [EW-1:0] mem [0:N-1];
reg [N-1:0] ent_valid;
reg [31:0] tx_word;
reg frame_end_pending;
reg [6:0] frame_msg_count;

wire sck_s;
wire ss_n_s;
wire mosi_s;
wire tx_taken;
wire rx_valid;
wire [31:0] rx_word;

// Link pins pass two flops before use
sync_bits #(
    .W(1),
    .RST(1'b0)
) u_sync_sck (
    .clk(clk),
    .rst_n(rst_n),
    .din(link_sck),
    .dout(sck_s)
);

sync_bits #(
    .W(1),
    .RST(1'b1)
) u_sync_ss (
    .clk(clk),
    .rst_n(rst_n),
    .din(link_ss_n),
    .dout(ss_n_s)
);

sync_bits #(
    .W(1),
    .RST(1'b0)
) u_sync_mosi (
    .clk(clk),
    .rst_n(rst_n),
    .din(link_mosi),
    .dout(mosi_s)
);

link_packet_port #(
    .W(32)
) u_port (
    .clk(clk),
    .rst_n(rst_n),
    .sck_s(sck_s),
    .ss_n_s(ss_n_s),
    .mosi_s(mosi_s),
    .miso(link_miso),
    .tx_word(tx_word),
    .tx_full(packet_pending),
    .tx_taken(tx_taken),
    .rx_valid(rx_valid),
    .rx_word(rx_word)
);

// Write index, and fields of the entry under the scan pointer
wire [IW-1:0] wr_idx = word_phase * SLOTS[IW-1:0] + {{(IW-3){1'b0}}, word_slot};
wire [EW-1:0] cur = mem[scan_idx];
wire [2:0] cur_kind = cur[EW-1 -: 3];
wire [6:0] cur_aux = cur[EW-4 -: 7];
wire [6:0] cur_wn = cur[EW-11 -: 7];
wire [DATA_W-1:0] cur_data = cur[DATA_W-1:0];
wire [IW-1:0] scan_phase = scan_idx / SLOTS[IW-1:0];
wire [1:0] cur_phase = scan_phase[1:0];
wire [2:0] cur_vtype = cur_data[`VECTOR_TYPE_LSB +: 3];

// Frame already carries the most message words it can hold
wire msg_full = (frame_msg_count == `MAX_FRAME_MSG_WORDS);

// Packet type for the current entry; IDLE means nothing is sent
reg [2:0] cur_type;
always @*
begin
    case (cur_kind)
        `KIND_BIW: cur_type = biw_report_en ? `PKT_BIW : `PKT_IDLE;
        `KIND_ADDR: cur_type = `PKT_ADDR;
        `KIND_LADDR1: cur_type = `PKT_ADDR;
        `KIND_VECTOR: cur_type = `PKT_VECTOR;
        // Word after a long vector is tagged message upstream
        `KIND_MESSAGE: cur_type = msg_full ? `PKT_IDLE : `PKT_MESSAGE;
        default: cur_type = `PKT_IDLE;
    endcase
end

// Address packets report where the vector sits
wire [6:0] cur_pkt_wn = (cur_type == `PKT_ADDR) ? cur_aux : cur_wn;

wire frag_type = (cur_vtype == `VTYPE_SECURE) || (cur_vtype == `VTYPE_ALPHA) ||
    (cur_vtype == `VTYPE_HEXBIN);
wire scan_go = (state == S_SCAN) && !packet_pending;
wire scan_send = scan_go && ent_valid[scan_idx] && (cur_type != `PKT_IDLE);
wire status_send = (state == S_IDLE) && !packet_pending && frame_end_pending && !block_done;
wire count_inc = scan_send && (cur_type == `PKT_VECTOR) && frag_type;
wire count_dec = rx_valid && (rx_word[`PKT_TYPE_MSB:`PKT_TYPE_LSB] == `PKT_ALLFRAME) &&
    rx_word[`DECREMENT_ALLFRAME_POS];

// Word capture; a block arriving while busy is lost and flagged
always @(posedge clk)
begin
    if (word_valid && !block_busy)
    begin
        mem[wr_idx] <= {word_kind, word_aux, word_number, word_data};
    end
end

// Entry valid bits, cleared as the scan passes
always @(posedge clk)
begin
    if (!rst_n)
    begin
        ent_valid <= {N{1'b0}};
        word_overrun <= 1'b0;
    end
    else
    begin
        if (scan_go)
        begin
            ent_valid[scan_idx] <= 1'b0;
        end
        if (word_valid && !block_busy)
        begin
            ent_valid[wr_idx] <= 1'b1;
        end
        if (word_valid && block_busy)
        begin
            word_overrun <= 1'b1;
        end
    end
end

// Scan walks phase-major, slot ascending, so lower phases go first
always @(posedge clk)
begin
    if (!rst_n)
    begin
        state <= S_IDLE;
        scan_idx <= {IW{1'b0}};
        block_busy <= 1'b0;
    end
    else
    begin
        case (state)
            S_IDLE:
            begin
                if (block_done)
                begin
                    state <= S_SCAN;
                    scan_idx <= {IW{1'b0}};
                    block_busy <= 1'b1;
                end
            end
            S_SCAN:
            begin
                if (scan_go)
                begin
                    if (scan_idx == N[IW-1:0] - 1'b1)
                    begin
                        state <= S_IDLE;
                        block_busy <= 1'b0;
                    end
                    else
                    begin
                        scan_idx <= scan_idx + 1'b1;
                    end
                end
            end
            default:
            begin
                state <= S_IDLE;
                block_busy <= 1'b0;
            end
        endcase
    end
end

// Outgoing slot; one packet held until the host frames a read
always @(posedge clk)
begin
    if (!rst_n)
    begin
        tx_word <= `PACKET_RESET;
        packet_pending <= 1'b0;
        frame_done <= 1'b0;
    end
    else
    begin
        frame_done <= 1'b0;
        if (scan_send)
        begin
            tx_word <= {1'b0, cur_type, cur_phase, cur_pkt_wn, cur_data};
            packet_pending <= 1'b1;
        end
        else if (status_send)
        begin
            tx_word <= {1'b0, `PKT_STATUS, 2'b00, 7'h00,
                {{(DATA_W-1){1'b0}}, 1'b1}};
            packet_pending <= 1'b1;
            frame_done <= 1'b1;
        end
        else if (tx_taken)
        begin
            packet_pending <= 1'b0;
        end
    end
end

// End-of-frame request waits until the block scan is done
always @(posedge clk)
begin
    if (!rst_n)
    begin
        frame_end_pending <= 1'b0;
    end
    else if (frame_end)
    begin
        frame_end_pending <= 1'b1;
    end
    else if (status_send)
    begin
        frame_end_pending <= 1'b0;
    end
end

// Message words sent this frame; excess words are dropped, never wrapped
always @(posedge clk)
begin
    if (!rst_n)
    begin
        frame_msg_count <= `MSG_COUNT_RESET;
    end
    else if (status_send)
    begin
        frame_msg_count <= `MSG_COUNT_RESET;
    end
    else if (scan_send && (cur_type == `PKT_MESSAGE))
    begin
        frame_msg_count <= frame_msg_count + 7'h01;
    end
end

// All-frame counter; increment and decrement together cancel
always @(posedge clk)
begin
    if (!rst_n)
    begin
        allframe_count <= `COUNT_RESET;
    end
    else if (count_inc && !count_dec)
    begin
        if (allframe_count != {CNT_W{1'b1}})
        begin
            allframe_count <= allframe_count + 1'b1;
        end
    end
    else if (count_dec && !count_inc)
    begin
        if (allframe_count != {CNT_W{1'b0}})
        begin
            allframe_count <= allframe_count - 1'b1;
        end
    end
end

// Decode every frame while any reason remains
always @(posedge clk)
begin
    if (!rst_n)
    begin
        allframe_mode <= 1'b0;
    end
    else
    begin
        allframe_mode <= (allframe_count != {CNT_W{1'b0}}) || temp_address_pending ||
            forced_allframe_bit;
    end
end

endmodule

// *** pager_packet_defs.vh ***
// Constants for the paging packet sequencer
`ifndef PAGER_PACKET_DEFS_VH
`define PAGER_PACKET_DEFS_VH

// Word kinds tagged by the upstream decoder
`define KIND_NONE 3'h0
`define KIND_BIW 3'h1
`define KIND_ADDR 3'h2
`define KIND_LADDR1 3'h3
`define KIND_LADDR2 3'h4
`define KIND_VECTOR 3'h5
`define KIND_MESSAGE 3'h6

// Packet type codes, both directions
`define PKT_IDLE 3'h0
`define PKT_ADDR 3'h1
`define PKT_VECTOR 3'h2
`define PKT_MESSAGE 3'h3
`define PKT_BIW 3'h4
`define PKT_STATUS 3'h5
`define PKT_ALLFRAME 3'h6

// Packet field layout, 32 bits, bit 31 reserved zero
`define PKT_TYPE_MSB 30
`define PKT_TYPE_LSB 28
`define PKT_PHASE_MSB 27
`define PKT_PHASE_LSB 26
`define PKT_WN_MSB 25
`define PKT_WN_LSB 19
`define PKT_DATA_MSB 18
`define PKT_DATA_LSB 0

// Host all-frame packet bits
`define DECREMENT_ALLFRAME_POS 0
`define TEMP_ADDRESS_DISABLE_POS 1

// Status packet end-of-frame bit
`define STATUS_EOF_POS 0

// Vector type field inside vector word data
`define VECTOR_TYPE_LSB 4
`define VTYPE_SECURE 3'h0
`define VTYPE_ALPHA 3'h5
`define VTYPE_HEXBIN 3'h6

// Largest message words in one frame
`define MAX_FRAME_MSG_WORDS 7'h54

// Reset values
`define COUNT_RESET 8'h00
`define PACKET_RESET 32'h0000_0000
`define MSG_COUNT_RESET 7'h00

`endif

// *** sync_bits.v ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_bits #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Asynchronous inputs and synchronised outputs
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

reg [W-1:0] meta;

// First stage feeds only the second
always @(posedge clk)
begin
    if (!rst_n)
    begin
        meta <= RST;
        dout <= RST;
    end
    else
    begin
        meta <= din;
        dout <= meta;
    end
end

endmodule

// *** link_packet_port.v ***
// Serial packet port sampled on the system clock
`timescale 1ns/1ps
module link_packet_port #(
    parameter W = 32
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Synchronised link pins
    input wire sck_s,
    input wire ss_n_s,
    input wire mosi_s,
    output reg miso,
    // Outgoing packet slot
    input wire [W-1:0] tx_word,
    input wire tx_full,
    output reg tx_taken,
    // Received packet
    output reg rx_valid,
    output reg [W-1:0] rx_word
);

reg sck_d;
reg ss_n_d;
reg [W-1:0] shift_out;
reg [W-1:0] shift_in;
reg [7:0] bit_cnt;

wire ss_fall = ss_n_d & ~ss_n_s;
wire ss_rise = ~ss_n_d & ss_n_s;
wire sck_rise = ~sck_d & sck_s & ~ss_n_s;
wire sck_fall = sck_d & ~sck_s & ~ss_n_s;

// Host samples on rising edge, device shifts on falling edge
always @(posedge clk)
begin
    if (!rst_n)
    begin
        sck_d <= 1'b0;
        ss_n_d <= 1'b1;
        shift_out <= {W{1'b0}};
        shift_in <= {W{1'b0}};
        bit_cnt <= 8'h00;
        miso <= 1'b0;
        tx_taken <= 1'b0;
        rx_valid <= 1'b0;
        rx_word <= {W{1'b0}};
    end
    else
    begin
        sck_d <= sck_s;
        ss_n_d <= ss_n_s;
        tx_taken <= 1'b0;
        rx_valid <= 1'b0;
        if (ss_fall)
        begin
            // Empty slot sends an idle packet of zeros
            shift_out <= tx_full ? tx_word : {W{1'b0}};
            miso <= tx_full ? tx_word[W-1] : 1'b0;
            tx_taken <= tx_full;
            bit_cnt <= 8'h00;
        end
        else if (sck_rise)
        begin
            shift_in <= {shift_in[W-2:0], mosi_s};
            bit_cnt <= bit_cnt + 8'h01;
        end
        else if (sck_fall)
        begin
            shift_out <= {shift_out[W-2:0], 1'b0};
            miso <= shift_out[W-2];
        end
        else if (ss_rise && bit_cnt == W[7:0])
        begin
            // Short frames are discarded
            rx_valid <= 1'b1;
            rx_word <= shift_in;
        end
    end
end

endmodule

// *** pager_packet_checker_assertions.sv ***
// Port-level checker for the packet sequencer
`timescale 1ns/1ps
module pager_packet_checker #(
    parameter CNT_W = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Inputs watched
    input wire word_valid,
    input wire block_done,
    input wire forced_allframe_bit,
    input wire temp_address_pending,
    // Outputs watched
    input wire block_busy,
    input wire word_overrun,
    input wire packet_pending,
    input wire frame_done,
    input wire [CNT_W-1:0] allframe_count,
    input wire allframe_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Any reason to keep decoding every frame
    wire want_mode = allframe_count != 0 || temp_address_pending || forced_allframe_bit;

    a_busy_overrun: assert property (word_valid && block_busy |=> word_overrun)
        else $error("word during scan not flagged");
    a_overrun_sticky: assert property (word_overrun |=> word_overrun)
        else $error("overrun flag dropped");
    a_block_start: assert property (block_done && !block_busy |=> block_busy)
        else $error("scan did not start");
    a_mode_on: assert property (want_mode |=> allframe_mode)
        else $error("all-frame mode missing");
    a_mode_off: assert property (!want_mode |=> !allframe_mode)
        else $error("all-frame mode stuck");
    // Counter moves by one step only
    a_count_step: assert property ($changed(allframe_count) |->
        (allframe_count - $past(allframe_count) == CNT_W'(1)) ||
        ($past(allframe_count) - allframe_count == CNT_W'(1)))
        else $error("counter jumped");
    a_zero_hold: assert property (allframe_count == 0 |=> allframe_count != {CNT_W{1'b1}})
        else $error("counter wrapped below zero");
    a_frame_done: assert property (frame_done |-> $rose(packet_pending) ##1 !frame_done)
        else $error("frame done without status load");
    // Main scenarios reached
    cover property (frame_done);
    cover property ($fell(allframe_mode));
    cover property (word_valid && block_busy);
endmodule

bind pager_packet_sequencer pager_packet_checker #(.CNT_W(CNT_W)) i_chk (
    .clk, .rst_n, .word_valid, .block_done, .forced_allframe_bit, .temp_address_pending,
    .block_busy, .word_overrun, .packet_pending, .frame_done, .allframe_count,
    .allframe_mode
);

// *** host_link_model.sv ***
// Host model: serial master on the packet link
`timescale 1ns/1ps
module host_link_model (
    // Pacing clock
    input wire clk,
    // Link pins
    output reg sck,
    output reg ss_n,
    output reg mosi,
    input wire miso
);
    integer i;
    // Link idles with clock low and select high
    initial
    begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // One frame, msb first both ways; half period 4 clocks
    task xfer(input [31:0] tx, output [31:0] rx);
        begin
            ss_n = 1'b0;
            for (i = 31; i >= 0; i = i - 1)
            begin
                mosi = tx[i];
                tick(4);
                sck = 1'b1;
                rx[i] = miso;
                tick(4);
                sck = 1'b0;
            end
            tick(4);
            ss_n = 1'b1;
            // Released line must not look like valid data
            mosi = ~mosi;
            tick(4);
        end
    endtask
    // Decrement request, sent once per finished fragment count
    task dec_allframe;
        reg [31:0] junk;
        begin
            xfer(32'h6000_0001, junk);
        end
    endtask
    // Temporary address release: disable bit only, no decrement
    task end_temp;
        reg [31:0] junk;
        begin
            xfer(32'h6000_0002, junk);
        end
    endtask
endmodule

// *** test_pager_packet_sequencer.sv ***
// Self-checking bench for the packet sequencer
`timescale 1ns/1ps
`include "pager_packet_defs.vh"
module test_pager_packet_sequencer;
    reg clk;
    reg rst_n;
    reg word_valid;
    reg [1:0] word_phase;
    reg [2:0] word_slot;
    reg [6:0] word_number;
    reg [2:0] word_kind;
    reg [6:0] word_aux;
    reg [18:0] word_data;
    reg block_done;
    reg frame_end;
    reg biw_report_en;
    reg forced_allframe_bit;
    reg temp_address_pending;
    wire link_sck, link_ss_n, link_mosi, link_miso;
    wire block_busy, word_overrun, packet_pending, frame_done, allframe_mode;
    wire [7:0] allframe_count;
    integer n_mismatch;
    integer num_checks;

    pager_packet_sequencer i_dut (.clk, .rst_n, .word_valid, .word_phase, .word_slot,
        .word_number, .word_kind, .word_aux, .word_data, .block_done, .frame_end,
        .biw_report_en, .forced_allframe_bit, .temp_address_pending, .link_sck,
        .link_ss_n, .link_mosi, .link_miso, .block_busy, .word_overrun,
        .packet_pending, .frame_done, .allframe_count, .allframe_mode);
    host_link_model i_host (.clk, .sck(link_sck), .ss_n(link_ss_n), .mosi(link_mosi),
        .miso(link_miso));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task check(input [31:0] seen, input [31:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want)
            begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    function [31:0] pk(input [2:0] t, input [1:0] ph, input [6:0] wn, input [18:0] d);
        pk = {1'b0, t, ph, wn, d};
    endfunction
    // Strobe stays high across back-to-back writes
    task put(input [1:0] ph, input [2:0] sl, input [6:0] wn, input [2:0] k, input [6:0] ax,
        input [18:0] d);
        begin
            word_valid = 1'b1;
            {word_phase, word_slot, word_number, word_kind, word_aux, word_data} =
                {ph, sl, wn, k, ax, d};
            cyc(1);
        end
    endtask
    task run_block;
        begin
            word_valid = 1'b0;
            cyc(1);
            block_done = 1'b1;
            cyc(1);
            block_done = 1'b0;
            cyc(1);
        end
    endtask
    // Bounded wait for a loaded packet, then read it over the link
    task get_pkt(input [31:0] want);
        integer i;
        reg [31:0] got;
        begin
            i = 0;
            while (packet_pending !== 1'b1 && i < 3000)
            begin
                cyc(1);
                i = i + 1;
            end
            if (i == 3000)
            begin
                n_mismatch = n_mismatch + 1;
                stop_test;
            end
            i_host.xfer(32'h0000_0000, got);
            check(got, want);
        end
    endtask
    // Higher phase written first; output must still start at phase 0
    task sc_block;
        begin
            put(2'd2, 3'd0, 7'd5, `KIND_LADDR1, 7'd10, 19'h0_0555);
            put(2'd2, 3'd1, 7'd6, `KIND_LADDR2, 7'd0, 19'h0_0666);
            put(2'd2, 3'd2, 7'd10, `KIND_VECTOR, 7'd0, 19'h0_0050);
            put(2'd2, 3'd3, 7'd11, `KIND_MESSAGE, 7'd0, 19'h1_1111);
            put(2'd0, 3'd0, 7'd0, `KIND_BIW, 7'd0, 19'h0_0abc);
            put(2'd0, 3'd1, 7'd3, `KIND_ADDR, 7'd7, 19'h0_0333);
            put(2'd0, 3'd2, 7'd7, `KIND_VECTOR, 7'd0, 19'h0_0060);
            put(2'd0, 3'd3, 7'd9, `KIND_MESSAGE, 7'd0, 19'h2_2222);
            put(2'd0, 3'd4, 7'd10, `KIND_MESSAGE, 7'd0, 19'h3_3333);
            run_block;
            put(2'd1, 3'd0, 7'd1, `KIND_MESSAGE, 7'd0, 19'h7_7777);
            word_valid = 1'b0;
            cyc(1);
            check(word_overrun, 1);
            check(block_busy, 1);
            get_pkt(pk(`PKT_ADDR, 2'd0, 7'd7, 19'h0_0333));
            get_pkt(pk(`PKT_VECTOR, 2'd0, 7'd7, 19'h0_0060));
            get_pkt(pk(`PKT_MESSAGE, 2'd0, 7'd9, 19'h2_2222));
            get_pkt(pk(`PKT_MESSAGE, 2'd0, 7'd10, 19'h3_3333));
            get_pkt(pk(`PKT_ADDR, 2'd2, 7'd10, 19'h0_0555));
            get_pkt(pk(`PKT_VECTOR, 2'd2, 7'd10, 19'h0_0050));
            get_pkt(pk(`PKT_MESSAGE, 2'd2, 7'd11, 19'h1_1111));
            cyc(2);
            check(block_busy, 0);
            check(allframe_count, 8'h02);
        end
    endtask
    // Reported block info, a plain vector, a secure vector, then frame end
    task sc_frame;
        begin
            biw_report_en = 1'b1;
            put(2'd1, 3'd0, 7'd0, `KIND_BIW, 7'd0, 19'h0_0bcd);
            put(2'd1, 3'd1, 7'd8, `KIND_VECTOR, 7'd0, 19'h0_0010);
            put(2'd1, 3'd2, 7'd9, `KIND_VECTOR, 7'd0, 19'h0_0000);
            run_block;
            frame_end = 1'b1;
            cyc(1);
            frame_end = 1'b0;
            get_pkt(pk(`PKT_BIW, 2'd1, 7'd0, 19'h0_0bcd));
            get_pkt(pk(`PKT_VECTOR, 2'd1, 7'd8, 19'h0_0010));
            get_pkt(pk(`PKT_VECTOR, 2'd1, 7'd9, 19'h0_0000));
            get_pkt(32'h5000_0001);
            cyc(2);
            check(packet_pending, 0);
            check(allframe_count, 8'h03);
        end
    endtask
    // Three full message blocks in one frame; words past the limit are dropped
    task sc_limit;
        reg [6:0] w;
        reg [6:0] r;
        begin
            for (w = 7'd0; w < 7'd96; w = w + 7'd1)
            begin
                put(w[4:3], w[2:0], w, `KIND_MESSAGE, 7'd0, {12'h000, w});
                if (w[4:0] == 5'h1f)
                begin
                    run_block;
                    for (r = w - 7'd31; r <= w; r = r + 7'd1)
                    begin
                        if (r < 7'd84)
                            get_pkt(pk(`PKT_MESSAGE, r[4:3], r, {12'h000, r}));
                    end
                end
            end
            frame_end = 1'b1;
            cyc(1);
            frame_end = 1'b0;
            get_pkt(32'h5000_0001);
        end
    endtask
    // Host decrements past zero, then the mode sources one by one
    task sc_count;
        integer k;
        begin
            i_host.end_temp;
            cyc(4);
            check(allframe_count, 8'h03);
            for (k = 1; k <= 4; k = k + 1)
            begin
                i_host.dec_allframe;
                cyc(4);
                check(allframe_count, (k > 3) ? 0 : 3 - k);
            end
            check(allframe_mode, 0);
            temp_address_pending = 1'b1;
            cyc(2);
            check(allframe_mode, 1);
            temp_address_pending = 1'b0;
            forced_allframe_bit = 1'b1;
            cyc(2);
            check(allframe_mode, 1);
            forced_allframe_bit = 1'b0;
            cyc(2);
            check(allframe_mode, 0);
            rst_n = 1'b0;
            cyc(3);
            rst_n = 1'b1;
            cyc(1);
            check(word_overrun, 0);
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        {word_valid, word_phase, word_slot, word_number, word_kind, word_aux} = 0;
        {word_data, block_done, frame_end, biw_report_en} = 0;
        {forced_allframe_bit, temp_address_pending} = 0;
        n_mismatch = 0;
        num_checks = 0;
        cyc(8);
        rst_n = 1'b1;
        cyc(3);
        sc_block;
        sc_frame;
        sc_limit;
        sc_count;
        stop_test;
    end
endmodule
